//--- include/dcms_map.svh
`ifndef DCMS_MAP_SVH
`define DCMS_MAP_SVH
// ==========================================
// register byte offsets
`define DCMS_OFF_CTRL 8'h00
`define DCMS_OFF_CMD 8'h04
`define DCMS_OFF_STAT 8'h08
`define DCMS_OFF_SRCA 8'h0C
`define DCMS_OFF_SRCB 8'h10
`define DCMS_OFF_LEN 8'h14
`define DCMS_OFF_MATCH 8'h18
`define DCMS_OFF_COUNT 8'h1C
// ==========================================
// control word fields
`define DCMS_CTRL_W 17
`define DCMS_C_CLS 0
`define DCMS_C_MODE 3
`define DCMS_C_A_IO 5
`define DCMS_C_B_IO 6
`define DCMS_C_A_SRC 7
`define DCMS_C_A_STEP 8
`define DCMS_C_B_STEP 10
`define DCMS_C_FRDY 12
`define DCMS_C_STOPM 13
`define DCMS_C_IE_RDY 14
`define DCMS_C_IE_MAT 15
`define DCMS_C_IE_EOB 16
// ==========================================
// command and status bits
`define DCMS_K_EN 0
`define DCMS_K_DIS 1
`define DCMS_K_CLR 2
`define DCMS_S_EOB 0
`define DCMS_S_MAT 1
`define DCMS_S_PEND 2
`define DCMS_S_ERR 3
`define DCMS_S_RDY 4
`define DCMS_S_MAST 5
`define DCMS_S_RUN 6
// ==========================================
// reset values and timing
`define DCMS_CTRL_RST 17'h00000
`define DCMS_WORD_RST 16'h0000
`define DCMS_BUS_CYC 4
`define DCMS_RESP_OK 2'h0
`define DCMS_RESP_ERR 2'h2
`endif

//--- include/dcms_pkg.sv
`default_nettype none
package dcms_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0, ST_POLL = 4'h1, ST_REQ = 4'h2, ST_CHK = 4'h3,
        ST_SSRC = 4'h4, ST_RD = 4'h5, ST_SDST = 4'h6, ST_WR = 4'h7,
        ST_SIM = 4'h8, ST_FIN = 4'h9, ST_REL = 4'hA
    } dcms_state_t;
    typedef enum logic [2:0] {
        CL_SEQ = 3'h0, CL_SIM = 3'h1, CL_SRCH = 3'h2, CL_SEQ_S = 3'h3, CL_SIM_S = 3'h4
    } dcms_class_t;
    typedef enum logic [1:0] {
        MD_BYTE = 2'h0, MD_BURST = 2'h1, MD_CONT = 2'h2
    } dcms_mode_t;
    typedef logic [7:0] dcms_addr_t;
endpackage
`default_nettype wire

//--- include/dcms_cmp_if.sv
`default_nettype none
interface dcms_cmp_if;
    logic [7:0] data;
    logic [7:0] match;
    logic [7:0] mask;
    logic hit;
    modport seq (output data, output match, output mask, input hit);
    modport cmp (input data, input match, input mask, output hit);
endinterface
`default_nettype wire

//--- logic/dcms_match.sv
`default_nettype none
// ==========================================
// masked byte compare; a mask bit of one leaves that bit out
module dcms_match (
    dcms_cmp_if.cmp c
);
    always_comb begin
        c.hit = ((c.data ^ c.match) & ~c.mask) == 8'h00; // R3
    end
endmodule
`default_nettype wire

//--- logic/dcms_seq.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`include "dcms_map.svh"
`default_nettype none
// What this block does
// R1 - sequential: read, latch, then drive write
// R2 - simultaneous: one cycle, source to destination
// R3 - search: compare masked byte to match
// R4 - combined classes transfer and compare together
// R5 - single-cycle only between memory and I/O
// R6 - device drives address, data, control as master
// R7 - forced ready replaces external ready
// R8 - step source, read, step destination, write
// R9 - no match counts on; match sets flag
// R10 - byte once read always completes
// R11 - start on enable, request only when ready
// R12 - host acknowledges and releases bus
// R13 - count equals length sets end flag, stops
// R14 - byte mode releases bus after each byte
// R15 - host gets a cycle between tenures
// R16 - burst runs back to back until stop
// R17 - burst releases on not ready, re-requests
// R18 - continuous holds bus while ready inactive
// R19 - length programmed one less than count
// R20 - registers reachable only while not master
// R21 - pending set after release or before request
// R22 - request drop and driver release together
module dcms_seq #(
    parameter int ADDR_W = 16,
    parameter int CYC_LEN = `DCMS_BUS_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire dcms_pkg::dcms_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire dcms_pkg::dcms_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic bus_req_o,
    input wire logic bus_ack_i,
    input wire logic rdy_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic ctl_oe_o,
    output logic mem_sel_o,
    output logic io_sel_o,
    output logic rd_o,
    output logic wr_o,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o
);
    import dcms_pkg::*;
    localparam int CW = $clog2(CYC_LEN);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_LEN - 1);

    if (ADDR_W < 8 || ADDR_W > 16 || CYC_LEN < 3 || CYC_LEN > 16) begin : g_bad_param
        $error("dcms_seq: unsupported parameter values");
    end

    // ==========================================
    // pin synchronisers
    logic ack_m, ack_s, rdy_m, rdy_s;
    logic [7:0] din_m, din_s;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {ack_m, ack_s, rdy_m, rdy_s} <= 4'h0;
            din_m <= 8'h00;
            din_s <= 8'h00;
        end else begin
            {ack_m, ack_s, rdy_m, rdy_s} <= {bus_ack_i, ack_m, rdy_i, rdy_m};
            din_m <= data_i;
            din_s <= din_m;
        end
    end

    // ==========================================
    // register slave state
    logic [`DCMS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [15:0] sa_r, sa_nxt, sb_r, sb_nxt, len_r, len_nxt, mm_r, mm_nxt;
    logic aw_r, aw_nxt, w_r, w_nxt, awrdy_nxt, wrdy_nxt, arrdy_nxt;
    dcms_addr_t awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rdata_nxt, wm;
    logic [3:0] ws_r, ws_nxt;
    logic bv_nxt, rv_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic en_r, en_nxt, dis_r, dis_nxt, clr_r, clr_nxt;

    // sequencer state
    dcms_state_t st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [15:0] ca_r, ca_nxt, cb_r, cb_nxt, bc_r, bc_nxt;
    logic [7:0] buf_r, buf_nxt, dout_nxt;
    logic run_r, run_nxt, eob_r, eob_nxt, mat_r, mat_nxt;
    logic pend_r, pend_nxt, err_r, err_nxt;
    logic req_nxt, coe_nxt, doe_nxt, rd_nxt, wr_nxt, msel_nxt, isel_nxt;
    logic [ADDR_W-1:0] addr_nxt;

    dcms_class_t cls;
    dcms_mode_t mode;
    logic a_src, src_io, dst_io, is_sim, srch, no_wr, rdy_eff, on_bus, eob_hit, hit;
    logic [15:0] src_a, dst_a, mem_a;
    dcms_cmp_if cmp_bus ();

    assign cls = dcms_class_t'(ctrl_r[`DCMS_C_CLS +: 3]);
    assign mode = dcms_mode_t'(ctrl_r[`DCMS_C_MODE +: 2]);
    assign a_src = ctrl_r[`DCMS_C_A_SRC];
    assign src_io = a_src ? ctrl_r[`DCMS_C_A_IO] : ctrl_r[`DCMS_C_B_IO];
    assign dst_io = a_src ? ctrl_r[`DCMS_C_B_IO] : ctrl_r[`DCMS_C_A_IO];
    assign is_sim = cls == CL_SIM || cls == CL_SIM_S;
    assign srch = cls == CL_SRCH || cls == CL_SEQ_S || cls == CL_SIM_S; // R4
    assign no_wr = cls == CL_SRCH;
    // forced ready lets memory-to-memory run without a ready pin
    assign rdy_eff = ctrl_r[`DCMS_C_FRDY] | rdy_s; // R7
    assign on_bus = st_r != ST_IDLE && st_r != ST_POLL;
    assign eob_hit = bc_r == len_r; // R19
    assign cmp_bus.data = buf_r;
    assign cmp_bus.match = mm_r[7:0];
    assign cmp_bus.mask = mm_r[15:8];
    assign hit = cmp_bus.hit;

    dcms_match u_match (
        .c(cmp_bus.cmp)
    );

    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] s);
        step = s == 2'h1 ? a + 16'h0001 : (s == 2'h2 ? a - 16'h0001 : a);
    endfunction

    // ==========================================
    // register slave; parked while the device holds the bus
    always_comb begin
        ctrl_nxt = ctrl_r;
        sa_nxt = sa_r;
        sb_nxt = sb_r;
        len_nxt = len_r;
        mm_nxt = mm_r;
        aw_nxt = aw_r | (s_axi_awvalid & s_axi_awready);
        w_nxt = w_r | (s_axi_wvalid & s_axi_wready);
        awa_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awa_r;
        wd_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_r;
        ws_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws_r;
        bv_nxt = s_axi_bvalid & ~s_axi_bready;
        bresp_nxt = s_axi_bresp;
        rv_nxt = s_axi_rvalid & ~s_axi_rready;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        {en_nxt, dis_nxt, clr_nxt} = 3'h0;
        wm = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
        if (aw_r && w_r && !s_axi_bvalid) begin
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            bv_nxt = 1'b1;
            bresp_nxt = `DCMS_RESP_OK;
            case ({awa_r[7:2], 2'b00})
                `DCMS_OFF_CTRL: ctrl_nxt = (ctrl_r & ~wm[16:0]) | (wd_r[16:0] & wm[16:0]);
                `DCMS_OFF_CMD: begin
                    en_nxt = ws_r[0] & wd_r[`DCMS_K_EN];
                    dis_nxt = ws_r[0] & wd_r[`DCMS_K_DIS];
                    clr_nxt = ws_r[0] & wd_r[`DCMS_K_CLR];
                end
                `DCMS_OFF_SRCA: sa_nxt = (sa_r & ~wm[15:0]) | (wd_r[15:0] & wm[15:0]);
                `DCMS_OFF_SRCB: sb_nxt = (sb_r & ~wm[15:0]) | (wd_r[15:0] & wm[15:0]);
                `DCMS_OFF_LEN: len_nxt = (len_r & ~wm[15:0]) | (wd_r[15:0] & wm[15:0]);
                `DCMS_OFF_MATCH: mm_nxt = (mm_r & ~wm[15:0]) | (wd_r[15:0] & wm[15:0]);
                `DCMS_OFF_STAT, `DCMS_OFF_COUNT: bresp_nxt = `DCMS_RESP_OK;
                default: bresp_nxt = `DCMS_RESP_ERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt = 1'b1;
            rresp_nxt = `DCMS_RESP_OK;
            case ({s_axi_araddr[7:2], 2'b00})
                `DCMS_OFF_CTRL: rdata_nxt = {15'h0000, ctrl_r};
                `DCMS_OFF_CMD: rdata_nxt = 32'h00000000;
                `DCMS_OFF_STAT: rdata_nxt = {25'h0000000, run_r, bus_req_o, rdy_eff,
                    err_r, pend_r, mat_r, eob_r};
                `DCMS_OFF_SRCA: rdata_nxt = {16'h0000, sa_r};
                `DCMS_OFF_SRCB: rdata_nxt = {16'h0000, sb_r};
                `DCMS_OFF_LEN: rdata_nxt = {16'h0000, len_r};
                `DCMS_OFF_MATCH: rdata_nxt = {16'h0000, mm_r};
                `DCMS_OFF_COUNT: rdata_nxt = {16'h0000, bc_r};
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `DCMS_RESP_ERR;
                end
            endcase
        end
        // looking at next state closes the window before the request rises
        awrdy_nxt = !aw_nxt && (st_nxt == ST_IDLE || st_nxt == ST_POLL); // R20
        wrdy_nxt = !w_nxt && (st_nxt == ST_IDLE || st_nxt == ST_POLL); // R20
        arrdy_nxt = !rv_nxt && (st_nxt == ST_IDLE || st_nxt == ST_POLL); // R20
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `DCMS_CTRL_RST;
            {sa_r, sb_r, len_r, mm_r} <= {4{`DCMS_WORD_RST}};
            {aw_r, w_r, en_r, dis_r, clr_r} <= 5'h00;
            {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h0;
            {s_axi_bvalid, s_axi_rvalid} <= 2'h0;
            {s_axi_bresp, s_axi_rresp} <= 4'h0;
            awa_r <= 8'h00;
            wd_r <= 32'h00000000;
            ws_r <= 4'h0;
            s_axi_rdata <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            {sa_r, sb_r, len_r, mm_r} <= {sa_nxt, sb_nxt, len_nxt, mm_nxt};
            {aw_r, w_r, en_r, dis_r, clr_r} <= {aw_nxt, w_nxt, en_nxt, dis_nxt, clr_nxt};
            {s_axi_awready, s_axi_wready, s_axi_arready} <= {awrdy_nxt, wrdy_nxt, arrdy_nxt};
            {s_axi_bvalid, s_axi_rvalid} <= {bv_nxt, rv_nxt};
            {s_axi_bresp, s_axi_rresp} <= {bresp_nxt, rresp_nxt};
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            ws_r <= ws_nxt;
            s_axi_rdata <= rdata_nxt;
        end
    end

    // ==========================================
    // byte sequencer and bus pins
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        {ca_nxt, cb_nxt, bc_nxt, buf_nxt, run_nxt} = {ca_r, cb_r, bc_r, buf_r, run_r};
        // a flag raised in the cycle software clears it survives
        eob_nxt = eob_r & ~clr_r;
        mat_nxt = mat_r & ~clr_r;
        pend_nxt = pend_r & ~clr_r;
        err_nxt = err_r & ~clr_r;
        case (st_r)
            ST_IDLE: if (en_r) begin // R11
                if (is_sim && src_io == dst_io) begin
                    err_nxt = 1'b1; // R5
                end else begin
                    {ca_nxt, cb_nxt, bc_nxt, run_nxt} = {sa_r, sb_r, 16'h0000, 1'b1};
                    st_nxt = ST_POLL;
                end
            end
            ST_POLL: if (dis_r) begin
                run_nxt = 1'b0;
                st_nxt = ST_IDLE;
            end else if (rdy_eff && !ack_s) begin // R15
                pend_nxt = pend_nxt | ctrl_r[`DCMS_C_IE_RDY]; // R21
                st_nxt = ST_REQ; // R11
            end
            ST_REQ: if (ack_s) st_nxt = ST_CHK; // R12
            ST_CHK: if (rdy_eff) st_nxt = ST_SSRC;
                else if (mode != MD_CONT) st_nxt = ST_REL; // R17
                // continuous mode idles here still holding the bus
            ST_SSRC: begin // R8
                if (a_src) ca_nxt = step(ca_r, ctrl_r[`DCMS_C_A_STEP +: 2]);
                else cb_nxt = step(cb_r, ctrl_r[`DCMS_C_B_STEP +: 2]);
                st_nxt = is_sim ? ST_SDST : ST_RD;
                cnt_nxt = '0;
            end
            ST_RD, ST_WR, ST_SIM: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CYC_LAST) begin // R10
                    cnt_nxt = '0;
                    if (st_r != ST_WR) buf_nxt = din_s; // R1 R2 R3
                    st_nxt = (st_r == ST_RD && !no_wr) ? ST_SDST : ST_FIN;
                end
            end
            ST_SDST: begin // R8
                if (a_src) cb_nxt = step(cb_r, ctrl_r[`DCMS_C_B_STEP +: 2]);
                else ca_nxt = step(ca_r, ctrl_r[`DCMS_C_A_STEP +: 2]);
                st_nxt = is_sim ? ST_SIM : ST_WR; // R2
                cnt_nxt = '0;
            end
            ST_FIN: begin
                bc_nxt = bc_r + 16'h0001; // R9
                if (srch && hit) mat_nxt = 1'b1; // R9
                if (eob_hit) eob_nxt = 1'b1; // R13
                if (eob_hit || (srch && hit && ctrl_r[`DCMS_C_STOPM])) begin
                    run_nxt = 1'b0; // R13
                    st_nxt = ST_REL;
                end else if (mode == MD_BYTE) st_nxt = ST_REL; // R14
                else st_nxt = ST_CHK; // R16
            end
            ST_REL: if (!ack_s) begin // R15
                st_nxt = run_r ? ST_POLL : ST_IDLE; // R17
                if (!run_r && ((eob_r && ctrl_r[`DCMS_C_IE_EOB])
                        || (mat_r && ctrl_r[`DCMS_C_IE_MAT]))) pend_nxt = 1'b1; // R21
            end
            default: st_nxt = ST_IDLE;
        endcase
        src_a = a_src ? ca_nxt : cb_nxt;
        dst_a = a_src ? cb_nxt : ca_nxt;
        mem_a = src_io ? dst_a : src_a;
        // request held for the whole tenure, drivers enabled once granted and dropped with it
        req_nxt = st_nxt != ST_IDLE && st_nxt != ST_POLL && st_nxt != ST_REL
            && st_r != ST_POLL; // R22
        coe_nxt = req_nxt && st_nxt != ST_REQ; // R6 R22
        rd_nxt = st_nxt == ST_RD || st_nxt == ST_SIM;
        wr_nxt = st_nxt == ST_WR || st_nxt == ST_SIM; // R2
        doe_nxt = st_nxt == ST_WR; // R1
        dout_nxt = buf_nxt; // R1
        addr_nxt = addr_o;
        msel_nxt = 1'b0;
        isel_nxt = 1'b0;
        case (st_nxt)
            ST_RD: {addr_nxt, msel_nxt, isel_nxt} = {src_a[ADDR_W-1:0], !src_io, src_io};
            ST_WR: {addr_nxt, msel_nxt, isel_nxt} = {dst_a[ADDR_W-1:0], !dst_io, dst_io};
            ST_SIM: {addr_nxt, msel_nxt, isel_nxt} = {mem_a[ADDR_W-1:0], 2'h3};
            default: addr_nxt = addr_o;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            {ca_r, cb_r, bc_r} <= {3{`DCMS_WORD_RST}};
            buf_r <= 8'h00;
            {run_r, eob_r, mat_r, pend_r, err_r} <= 5'h00;
            {bus_req_o, ctl_oe_o, data_oe_o, rd_o, wr_o, mem_sel_o, io_sel_o} <= 7'h00;
            addr_o <= '0;
            data_o <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            {ca_r, cb_r, bc_r} <= {ca_nxt, cb_nxt, bc_nxt};
            buf_r <= buf_nxt;
            {run_r, eob_r, mat_r, pend_r, err_r} <= {run_nxt, eob_nxt, mat_nxt, pend_nxt, err_nxt};
            {bus_req_o, ctl_oe_o, data_oe_o, rd_o, wr_o} <=
                {req_nxt, coe_nxt, doe_nxt, rd_nxt, wr_nxt};
            {mem_sel_o, io_sel_o} <= {msel_nxt, isel_nxt};
            addr_o <= addr_nxt;
            data_o <= dout_nxt;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_req_after_ready: assert property ($rose(bus_req_o) |-> $past(st_r == ST_REQ) // R11
        && $past(rdy_eff, 2)) else $error("request without ready");
    a_drivers_drop: assert property ($fell(bus_req_o) |-> !ctl_oe_o && !data_oe_o) // R22
        else $error("drivers left on after request drop");
    a_drive_in_tenure: assert property ((rd_o || wr_o) |-> bus_req_o && ctl_oe_o) // R6
        else $error("strobe outside tenure");
    a_sim_legal: assert property (st_r == ST_SIM |-> src_io != dst_io && rd_o && wr_o) // R5
        else $error("flyby between like ports");
    a_write_data: assert property (st_r == ST_WR |-> data_oe_o && data_o == buf_r) // R1
        else $error("write data not held");
    a_step_order: assert property (st_r == ST_SSRC |=> st_r == ST_RD || st_r == ST_SDST) // R8
        else $error("source step not followed by read");
    a_search_no_wr: assert property (cls == CL_SRCH && st_r != ST_IDLE |-> !wr_o) // R3
        else $error("search class wrote");
    a_cont_hold: assert property (mode == MD_CONT && st_r == ST_CHK && !rdy_eff // R18
        |=> st_r == ST_CHK && bus_req_o) else $error("continuous gave up bus");
    a_burst_rel: assert property (mode == MD_BURST && st_r == ST_CHK && !rdy_eff // R17
        |=> st_r == ST_REL ##1 !bus_req_o) else $error("burst kept bus");
    a_byte_rel: assert property (mode == MD_BYTE && st_r == ST_FIN |=> st_r == ST_REL) // R14
        else $error("byte mode kept bus");
    a_eob_flag: assert property (st_r == ST_FIN && eob_hit |=> eob_r && !run_r) // R13
        else $error("end of block missed");
    a_match_flag: assert property (st_r == ST_FIN && srch && hit |=> mat_r) // R9
        else $error("match flag missed");
    a_read_done: assert property (st_r == ST_RD && cnt_r == CYC_LAST && !no_wr // R10
        |=> st_r == ST_SDST) else $error("byte abandoned after read");
    a_no_slave_master: assert property (bus_req_o |-> !s_axi_awready && !s_axi_arready) // R20
        else $error("register access while master");

    c_seq_byte: cover property (st_r == ST_WR ##[1:8] st_r == ST_FIN);
    c_sim_byte: cover property (st_r == ST_SIM ##[1:8] st_r == ST_FIN);
    c_match_stop: cover property (st_r == ST_FIN && srch && hit && !run_nxt);
    c_cont_wait: cover property (mode == MD_CONT && st_r == ST_CHK && !rdy_eff);
endmodule
`default_nettype wire

//--- verification/dcms_host_model.sv
`default_nettype none
// ==========================================
// host side: grants the bus and answers device reads
module dcms_host_model (
    input wire logic aclk,
    input wire logic slow,
    input wire logic bus_req_o,
    input wire logic rd_o,
    input wire logic [15:0] addr_o,
    output logic bus_ack_i,
    output logic [7:0] data_i
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    logic [7:0] last = 8'h00;
    initial bus_ack_i = 1'b0;
    // ack trails the request both ways, so the host keeps the bus at least a cycle
    always @(posedge aclk) begin
        n <= 0;
        if (bus_ack_i != bus_req_o) begin
            n <= n + 1;
            if (n >= (slow ? 3 : 0)) begin
                bus_ack_i <= bus_req_o;
                n <= 0;
            end
        end
    end
    // a released data bus shows the inverse of the last byte, never a stale copy
    always @(posedge aclk) begin
        if (rd_o) last <= addr_o[7:0] ^ 8'h5A;
    end
    assign data_i = rd_o ? addr_o[7:0] ^ 8'h5A : ~last;
endmodule
`default_nettype wire

//--- verification/dcms_class_mode_sequencer_bench.sv
`include "dcms_map.svh"
`default_nettype none
module dcms_class_mode_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, rdy_i = 1'b1, slow = 1'b0, drop = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rd_p = 1'b0, wr_p = 1'b0, rq_p = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, lfsr_r = 32'h00009571;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic bus_req_o, bus_ack_i, ctl_oe_o, mem_sel_o, io_sel_o, rd_o, wr_o, data_oe_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] addr_o, a_p;
    logic [7:0] data_i, data_o, d_p;
    logic [15:0] rq[$];
    logic [23:0] wq[$];
    int ten = 0, num_errors = 0, checks_done = 0;
    // ==========================================
    // scenario table: control word, length, mask, match byte index, ready drop
    logic [16:0] cfg[6] = '{17'h05580, 17'h002C9, 17'h0A192, 17'h1198B, 17'h014C4, 17'h01081};
    logic [15:0] len[6] = '{16'h0001, 16'h0003, 16'h0005, 16'h0003, 16'h0002, 16'h0001};
    logic [7:0] mk[6] = '{8'h00, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h00};
    int kk[6] = '{0, 0, 4, 2, 0, 0};
    logic dr[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    always #25 aclk = ~aclk;
    dcms_seq #(.CYC_LEN(3)) i_dcms_seq (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .bus_req_o, .bus_ack_i, .rdy_i, .addr_o, .ctl_oe_o, .mem_sel_o, .io_sel_o,
        .rd_o, .wr_o, .data_i, .data_o, .data_oe_o);
    dcms_host_model i_dcms_host_model (.aclk, .slow, .bus_req_o, .rd_o, .addr_o,
        .bus_ack_i, .data_i);
    function automatic logic [15:0] lfsr();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r[15:0];
    endfunction
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    function automatic logic [15:0] stp(input logic [15:0] a, input logic [1:0] s, input int k);
        return s == 2'h1 ? a + 16'(k) : s == 2'h2 ? a - 16'(k) : a;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // ==========================================
    // register bus master
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(d, ed);
        chk(r, er);
    endtask
    // ==========================================
    // bus monitor; a strobe is recorded the cycle after it falls, with its last cycle's address
    always @(posedge aclk) begin
        if (rd_p && !rd_o) rq.push_back(a_p);
        if (wr_p && !wr_o && !rd_p) wq.push_back({a_p, d_p});
        if (bus_req_o && !rq_p) ten++;
        if (rd_o && wr_o && data_oe_o) chk(1, 0);
        if (rq_p && !bus_req_o && ctl_oe_o) chk(1, 0);
        if ((rd_o || wr_o) && (mem_sel_o ^ io_sel_o) == (rd_o && wr_o)) chk(1, 0);
        rd_p <= rd_o;
        wr_p <= wr_o;
        rq_p <= bus_req_o;
        a_p <= addr_o;
        d_p <= data_o;
    end
    always @(posedge aclk) begin
        if (drop && rq.size() == 2) begin
            drop = 1'b0;
            rdy_i <= 1'b0;
            repeat (40) @(posedge aclk);
            rdy_i <= 1'b1;
        end
    end
    task automatic run(input int i);
        logic [16:0] c;
        logic [15:0] sa, sb, a;
        logic [15:0] erd[$];
        logic [23:0] ewr[$];
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] m;
        logic err, mat, stop, eob, pnd;
        int nb, et;
        c = cfg[i];
        sa = lfsr();
        sb = lfsr();
        m = pat(stp(sa, c[9:8], kk[i])) ^ mk[i];
        slow <= lfsr_r[3];
        rdy_i <= !c[12];
        axw(`DCMS_OFF_SRCA, sa, 2'h0);
        axw(`DCMS_OFF_SRCB, sb, 2'h0);
        axw(`DCMS_OFF_LEN, len[i], 2'h0);
        axw(`DCMS_OFF_MATCH, {mk[i], m}, 2'h0);
        axw(`DCMS_OFF_CTRL, c, 2'h0);
        axw(`DCMS_OFF_CMD, 32'h00000004, 2'h0);
        rq.delete();
        wq.delete();
        ten = 0;
        drop = dr[i];
        axw(`DCMS_OFF_CMD, 32'h00000001, 2'h0);
        err = (c[2:0] == 3'h1 || c[2:0] == 3'h4) && c[5] == c[6];
        mat = 1'b0;
        stop = 1'b0;
        nb = 0;
        for (int k = 1; k <= int'(len[i]) + 1 && !err && !stop; k++) begin
            a = stp(sa, c[9:8], k);
            erd.push_back(a);
            if (c[2:0] == 3'h0 || c[2:0] == 3'h3) ewr.push_back({stp(sb, c[11:10], k), pat(a)});
            nb++;
            if (c[2:0] >= 3'h2 && ((pat(a) ^ m) & ~mk[i]) == 8'h00) begin
                mat = 1'b1;
                stop = c[13];
            end
        end
        eob = nb == int'(len[i]) + 1;
        et = err ? 0 : c[4:3] == 2'h0 ? nb : (c[4:3] == 2'h1 && dr[i]) ? 2 : 1;
        do begin
            axr(`DCMS_OFF_STAT, d, r);
        end while (d[6]);
        pnd = !err && (c[14] || eob && c[16] || mat && c[15]);
        chk(ten, et);
        chk(rq.size(), erd.size());
        foreach (erd[j]) if (j < rq.size()) chk(rq[j], erd[j]);
        chk(wq.size(), ewr.size());
        foreach (ewr[j]) if (j < wq.size()) chk(wq[j], ewr[j]);
        chk(d[3:0], {err, pnd, mat, eob});
    endtask
    task automatic final_report;
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdy_i <= 1'b0;
        rchk(`DCMS_OFF_CTRL, `DCMS_CTRL_RST, 2'h0);
        rchk(`DCMS_OFF_LEN, `DCMS_WORD_RST, 2'h0);
        rchk(8'h20, 32'h00000000, `DCMS_RESP_ERR);
        axw(8'h20, 32'hFFFFFFFF, `DCMS_RESP_ERR);
        axw(`DCMS_OFF_COUNT, 32'h0000FFFF, `DCMS_RESP_OK);
        rchk(`DCMS_OFF_COUNT, `DCMS_WORD_RST, 2'h0);
        axw(`DCMS_OFF_CMD, 32'h00000001, 2'h0);
        axw(`DCMS_OFF_CMD, 32'h00000002, 2'h0);
        rchk(`DCMS_OFF_STAT, 32'h00000000, 2'h0);
        for (int i = 0; i < 6; i++) run(i);
        final_report;
    end
    initial begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
